//--- divide_ratio_track.sv
// Purpose: registered feedback ratio terms and profile sanity flags
// Assumes: inputs are register outputs in the same clock domain
// Notes: one cycle of latency from register to output
`timescale 1ns/1ps
`include "dpll_ref_params.svh"
module divide_ratio_track (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [16:0] stored_count_in,
  input  wire logic [22:0] numerator_in,
  input  wire logic [22:0] denominator_in,
  input  wire logic [15:0] bw_scale_in,
  output logic      [17:0] integer_ratio_out,
  output logic             bw_high_out,
  output logic             fraction_bad_out
);
  logic [17:0] next_integer_ratio;

  always_comb begin
    next_integer_ratio = {1'b0, stored_count_in} + 18'h00001;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      integer_ratio_out <= {1'b0, `INT_DIV_RESET} + 18'h00001;
    end else begin
      integer_ratio_out <= next_integer_ratio;
    end
  end

  // advisory only: the loop still runs what software programmed
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      bw_high_out      <= 1'b0;
      fraction_bad_out <= 1'b0;
    end else begin
      bw_high_out      <= (bw_scale_in > `BW_HIGH_MARGIN_MIN);
      fraction_bad_out <= (denominator_in == 23'h000000) || (numerator_in >= denominator_in);
    end
  end
endmodule // divide_ratio_track

//--- dpll_ref_params.svh
// Purpose: constants for the reference-four profile register bank
// Assumes: registers sit one per 32-bit word, byte address = 4 * index
// Notes: indices are printed offsets; data sits in the low byte
//
// Notes on behaviour
// - two-bit priority at bits [2:1], code 00 highest and reset, 11 lowest.
// - priority register bit 0 set lets the first loop use reference four.
// - sixteen-bit bandwidth factor over two bytes, low first, 0.1 Hz steps.
// - bandwidth factor resets to 0x01f4, low 0xf4 and high 0x01, 50 Hz.
// - filter-select bit 1 picks high phase margin; 0 and reset give 70 degrees.
// - integer divider minus one, 17 bits over three bytes, resets to 0x007cb.
// - fraction numerator 23 bits over three bytes, top uses 6:0, resets 0x04.
// - fraction denominator 23 bits over three bytes, top uses 6:0, resets 0x05.
`ifndef DPLL_REF_PARAMS_SVH
`define DPLL_REF_PARAMS_SVH

`define NUM_CFG_REGS        13
`define IDX_PRIORITY_ENABLE 12'h467
`define IDX_BW_SCALE_LOW    12'h468
`define IDX_BW_SCALE_HIGH   12'h469
`define IDX_FILTER_SELECT   12'h46a
`define IDX_INT_DIV_LOW     12'h46b
`define IDX_INT_DIV_MID     12'h46c
`define IDX_INT_DIV_TOP     12'h46d
`define IDX_FRAC_NUM_LOW    12'h46e
`define IDX_FRAC_NUM_MID    12'h46f
`define IDX_FRAC_NUM_TOP    12'h470
`define IDX_FRAC_DEN_LOW    12'h471
`define IDX_FRAC_DEN_MID    12'h472
`define IDX_FRAC_DEN_TOP    12'h473
`define IDX_PROFILE_STATUS  12'h474

`define RST_PRIORITY_ENABLE 8'h00
`define RST_BW_SCALE_LOW    8'hf4
`define RST_BW_SCALE_HIGH   8'h01
`define RST_FILTER_SELECT   8'h00
`define RST_INT_DIV_LOW     8'hcb
`define RST_INT_DIV_MID     8'h07
`define RST_INT_DIV_TOP     8'h00
`define RST_FRAC_NUM_LOW    8'h04
`define RST_FRAC_DEN_LOW    8'h05
`define RST_ZERO            8'h00

`define MASK_PRIORITY_ENABLE 8'h07
`define MASK_FILTER_SELECT   8'h02
`define MASK_INT_DIV_TOP     8'h01
`define MASK_FRAC_TOP        8'h7f
`define MASK_FULL            8'hff

`define BIT_REF_ENABLE      0
`define BIT_PRIORITY_LO     1
`define BIT_PRIORITY_HI     2
`define BIT_HIGH_MARGIN     1
`define BIT_STAT_BW_HIGH    0
`define BIT_STAT_FRAC_BAD   1

`define BW_SCALE_RESET      16'h01f4
`define BW_HIGH_MARGIN_MIN  16'h4e20
`define INT_DIV_RESET       17'h007cb

`endif

//--- dpll_ref_pkg.sv
// Purpose: shared types for the reference-four profile register bank
// Assumes: nothing beyond the constants header
// Notes: bus handshake states and the configuration byte type
package dpll_ref_pkg;
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_e;
  typedef logic [7:0] cfg_byte_t;
endpackage

//--- dpll_reference_profile_regs.sv
// Purpose: profile registers the first digital loop applies to reference four
// Assumes: Avalon-MM slave, byte addresses, one wait cycle per access
// Notes: reserved bits are never stored, so they read zero
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "dpll_ref_params.svh"
module dpll_reference_profile_regs (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RSTN_IN,
  input  wire logic [13:0] AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  output logic             REF_FOUR_ENABLE_OUT,
  output logic      [1:0]  REF_FOUR_PRIORITY_OUT,
  output logic      [15:0] LOOP_BW_SCALE_OUT,
  output logic             HIGH_MARGIN_FILTER_OUT,
  output logic      [16:0] INTEGER_FEEDBACK_COUNT_OUT,
  output logic      [22:0] FRACTION_NUMERATOR_OUT,
  output logic      [22:0] FRACTION_DENOMINATOR_OUT,
  output logic      [17:0] INTEGER_RATIO_OUT,
  output logic             BW_HIGH_OUT,
  output logic             FRACTION_BAD_OUT
);
  localparam int NUM = `NUM_CFG_REGS;

  localparam dpll_ref_pkg::cfg_byte_t RESET_VAL [0:NUM-1] = '{
    `RST_PRIORITY_ENABLE, `RST_BW_SCALE_LOW, `RST_BW_SCALE_HIGH,
    `RST_FILTER_SELECT,   `RST_INT_DIV_LOW,  `RST_INT_DIV_MID,
    `RST_INT_DIV_TOP,     `RST_FRAC_NUM_LOW, `RST_ZERO,
    `RST_ZERO,            `RST_FRAC_DEN_LOW, `RST_ZERO,
    `RST_ZERO
  };

  localparam dpll_ref_pkg::cfg_byte_t WRITE_MASK [0:NUM-1] = '{
    `MASK_PRIORITY_ENABLE, `MASK_FULL,     `MASK_FULL,
    `MASK_FILTER_SELECT,   `MASK_FULL,     `MASK_FULL,
    `MASK_INT_DIV_TOP,     `MASK_FULL,     `MASK_FULL,
    `MASK_FRAC_TOP,        `MASK_FULL,     `MASK_FULL,
    `MASK_FRAC_TOP
  };

  dpll_ref_pkg::cfg_byte_t  cfg [0:NUM-1];
  dpll_ref_pkg::bus_state_e bus_state;
  dpll_ref_pkg::bus_state_e next_bus_state;
  logic [11:0]              word_idx;
  logic [11:0]              entry_off;
  logic                     aligned;
  logic                     cfg_hit;
  logic                     status_hit;
  logic                     wr_commit;
  logic [31:0]              next_readdata;
  logic [17:0]              integer_ratio;
  logic                     bw_high;
  logic                     fraction_bad;

  // address decode
  always_comb begin
    word_idx   = AVS_ADDRESS_IN[13:2];
    entry_off  = word_idx - `IDX_PRIORITY_ENABLE;
    aligned    = (AVS_ADDRESS_IN[1:0] == 2'h0);
    cfg_hit    = aligned && (word_idx >= `IDX_PRIORITY_ENABLE)
                 && (word_idx <= `IDX_FRAC_DEN_TOP);
    status_hit = aligned && (word_idx == `IDX_PROFILE_STATUS);
  end

  // write lands only at the edge where the master sees waitrequest low
  always_comb begin
    wr_commit = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && cfg_hit
                && AVS_BYTEENABLE_IN[0];
  end

  // bus handshake
  always_comb begin
    case (bus_state)
      dpll_ref_pkg::BUS_IDLE: begin
        if (AVS_READ_IN || AVS_WRITE_IN) begin
          next_bus_state = dpll_ref_pkg::BUS_ANSWER;
        end else begin
          next_bus_state = dpll_ref_pkg::BUS_IDLE;
        end
      end
      dpll_ref_pkg::BUS_ANSWER: begin
        next_bus_state = dpll_ref_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = dpll_ref_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      bus_state           <= dpll_ref_pkg::BUS_IDLE;
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      bus_state           <= next_bus_state;
      AVS_WAITREQUEST_OUT <= (next_bus_state != dpll_ref_pkg::BUS_ANSWER);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_readdata = 32'h00000000;
    if (cfg_hit) begin
      next_readdata = {24'h000000, cfg[entry_off[3:0]]};
    end else if (status_hit) begin
      next_readdata[`BIT_STAT_BW_HIGH]  = bw_high;
      next_readdata[`BIT_STAT_FRAC_BAD] = fraction_bad;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      AVS_READDATA_OUT <= 32'h00000000;
    end else if (AVS_READ_IN && (bus_state == dpll_ref_pkg::BUS_IDLE)) begin
      AVS_READDATA_OUT <= next_readdata;
    end
  end

  // register storage, one flop byte per entry
  generate
    for (genvar g = 0; g < NUM; g++) begin : g_entry
      always_ff @(posedge CLK_SYS_IN) begin
        if (!RSTN_IN) begin
          cfg[g] <= RESET_VAL[g];
        end else if (wr_commit && (entry_off[3:0] == 4'(g))) begin
          cfg[g] <= AVS_WRITEDATA_IN[7:0] & WRITE_MASK[g];
        end
      end
    end
  endgenerate

  // fields presented to selection, loop filter and feedback divider
  always_comb begin
    REF_FOUR_ENABLE_OUT        = cfg[0][`BIT_REF_ENABLE];
    REF_FOUR_PRIORITY_OUT      = cfg[0][`BIT_PRIORITY_HI:`BIT_PRIORITY_LO];
    LOOP_BW_SCALE_OUT          = {cfg[2], cfg[1]};
    HIGH_MARGIN_FILTER_OUT     = cfg[3][`BIT_HIGH_MARGIN];
    INTEGER_FEEDBACK_COUNT_OUT = {cfg[6][0], cfg[5], cfg[4]};
    FRACTION_NUMERATOR_OUT     = {cfg[9][6:0], cfg[8], cfg[7]};
    FRACTION_DENOMINATOR_OUT   = {cfg[12][6:0], cfg[11], cfg[10]};
    INTEGER_RATIO_OUT          = integer_ratio;
    BW_HIGH_OUT                = bw_high;
    FRACTION_BAD_OUT           = fraction_bad;
  end

  divide_ratio_track u_ratio (
    .clk_in            (CLK_SYS_IN),
    .rstn_in           (RSTN_IN),
    .stored_count_in   ({cfg[6][0], cfg[5], cfg[4]}),
    .numerator_in      ({cfg[9][6:0], cfg[8], cfg[7]}),
    .denominator_in    ({cfg[12][6:0], cfg[11], cfg[10]}),
    .bw_scale_in       ({cfg[2], cfg[1]}),
    .integer_ratio_out (integer_ratio),
    .bw_high_out       (bw_high),
    .fraction_bad_out  (fraction_bad)
  );

  // checks
  chk_wait_one_cycle:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
      && (bus_state == dpll_ref_pkg::BUS_IDLE) |=> !AVS_WAITREQUEST_OUT)
    else $error("waitrequest did not drop one cycle after request");

  chk_wait_release:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest stayed low for more than one cycle");

  chk_bw_after_reset:
    assert property (@(posedge CLK_SYS_IN)
      !RSTN_IN |=> (LOOP_BW_SCALE_OUT == `BW_SCALE_RESET) && !REF_FOUR_ENABLE_OUT
      && (REF_FOUR_PRIORITY_OUT == 2'h0) && !HIGH_MARGIN_FILTER_OUT)
    else $error("profile reset values wrong");

  chk_div_after_reset:
    assert property (@(posedge CLK_SYS_IN)
      !RSTN_IN |=> (INTEGER_FEEDBACK_COUNT_OUT == `INT_DIV_RESET)
      && (FRACTION_NUMERATOR_OUT == 23'h000004)
      && (FRACTION_DENOMINATOR_OUT == 23'h000005))
    else $error("divider reset values wrong");

  chk_priority_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_PRIORITY_ENABLE)
      |=> REF_FOUR_PRIORITY_OUT == $past(AVS_WRITEDATA_IN[2:1]))
    else $error("priority field not taken from write");

  chk_enable_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_PRIORITY_ENABLE)
      |=> REF_FOUR_ENABLE_OUT == $past(AVS_WRITEDATA_IN[0]))
    else $error("reference enable not taken from write");

  chk_bw_low_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_BW_SCALE_LOW)
      |=> (LOOP_BW_SCALE_OUT[7:0] == $past(AVS_WRITEDATA_IN[7:0]))
      && $stable(LOOP_BW_SCALE_OUT[15:8]))
    else $error("bandwidth low byte write wrong");

  chk_filter_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_FILTER_SELECT)
      |=> HIGH_MARGIN_FILTER_OUT == $past(AVS_WRITEDATA_IN[1]))
    else $error("filter select not taken from write");

  chk_int_top_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_INT_DIV_TOP)
      |=> INTEGER_FEEDBACK_COUNT_OUT[16] == $past(AVS_WRITEDATA_IN[0]))
    else $error("divider top bit not taken from write");

  chk_num_top_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_FRAC_NUM_TOP)
      |=> FRACTION_NUMERATOR_OUT[22:16] == $past(AVS_WRITEDATA_IN[6:0]))
    else $error("numerator top bits not taken from write");

  chk_den_top_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_FRAC_DEN_TOP)
      |=> FRACTION_DENOMINATOR_OUT[22:16] == $past(AVS_WRITEDATA_IN[6:0]))
    else $error("denominator top bits not taken from write");

  chk_ratio_follows:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      ##1 INTEGER_RATIO_OUT == {1'b0, $past(INTEGER_FEEDBACK_COUNT_OUT)} + 18'h00001)
    else $error("integer ratio is not stored count plus one");

  chk_reserved_zero:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      AVS_READ_IN && !AVS_WAITREQUEST_OUT && cfg_hit
      && (word_idx == `IDX_PRIORITY_ENABLE)
      |-> AVS_READDATA_OUT[31:3] == 29'h00000000)
    else $error("reserved bits of priority register read nonzero");

  chk_answer_state:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      !AVS_WAITREQUEST_OUT
      |-> bus_state == dpll_ref_pkg::BUS_ANSWER)
    else $error("waitrequest low outside the answer state");

  chk_wait_idle_high:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      (bus_state == dpll_ref_pkg::BUS_IDLE) && !AVS_READ_IN && !AVS_WRITE_IN
      |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest dropped with no request");

  chk_reset_outputs:
    assert property (@(posedge CLK_SYS_IN)
      !RSTN_IN |=> AVS_WAITREQUEST_OUT && (AVS_READDATA_OUT == 32'h00000000)
      && !BW_HIGH_OUT && !FRACTION_BAD_OUT
      && (INTEGER_RATIO_OUT == ({1'b0, `INT_DIV_RESET} + 18'h00001)))
    else $error("bus or derived outputs wrong after reset");

  chk_hold_no_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      !wr_commit |=> $stable(LOOP_BW_SCALE_OUT) && $stable(INTEGER_FEEDBACK_COUNT_OUT)
      && $stable(FRACTION_NUMERATOR_OUT) && $stable(FRACTION_DENOMINATOR_OUT)
      && $stable(REF_FOUR_PRIORITY_OUT) && $stable(REF_FOUR_ENABLE_OUT)
      && $stable(HIGH_MARGIN_FILTER_OUT))
    else $error("profile field changed without an accepted write");

  chk_bw_high_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_BW_SCALE_HIGH)
      |=> (LOOP_BW_SCALE_OUT[15:8] == $past(AVS_WRITEDATA_IN[7:0])) && $stable(LOOP_BW_SCALE_OUT[7:0]))
    else $error("bandwidth high byte write wrong");

  chk_int_low_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_INT_DIV_LOW)
      |=> INTEGER_FEEDBACK_COUNT_OUT[7:0] == $past(AVS_WRITEDATA_IN[7:0]))
    else $error("divider low byte not taken from write");

  chk_int_mid_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_INT_DIV_MID)
      |=> INTEGER_FEEDBACK_COUNT_OUT[15:8] == $past(AVS_WRITEDATA_IN[7:0]))
    else $error("divider middle byte not taken from write");

  chk_num_low_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_FRAC_NUM_LOW)
      |=> FRACTION_NUMERATOR_OUT[7:0] == $past(AVS_WRITEDATA_IN[7:0]))
    else $error("numerator low byte not taken from write");

  chk_num_mid_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_FRAC_NUM_MID)
      |=> FRACTION_NUMERATOR_OUT[15:8] == $past(AVS_WRITEDATA_IN[7:0]))
    else $error("numerator middle byte not taken from write");

  chk_den_low_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_FRAC_DEN_LOW)
      |=> FRACTION_DENOMINATOR_OUT[7:0] == $past(AVS_WRITEDATA_IN[7:0]))
    else $error("denominator low byte not taken from write");

  chk_den_mid_write:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      wr_commit && (word_idx == `IDX_FRAC_DEN_MID)
      |=> FRACTION_DENOMINATOR_OUT[15:8] == $past(AVS_WRITEDATA_IN[7:0]))
    else $error("denominator middle byte not taken from write");

  chk_filter_reserved:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      AVS_READ_IN && !AVS_WAITREQUEST_OUT && cfg_hit && (word_idx == `IDX_FILTER_SELECT)
      |-> (AVS_READDATA_OUT[31:2] == 30'h00000000) && !AVS_READDATA_OUT[0])
    else $error("reserved bits of filter register read nonzero");

  chk_int_top_reserved:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      AVS_READ_IN && !AVS_WAITREQUEST_OUT && cfg_hit && (word_idx == `IDX_INT_DIV_TOP)
      |-> AVS_READDATA_OUT[31:1] == 31'h00000000)
    else $error("reserved bits of divider top register read nonzero");

  chk_frac_top_reserved:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      AVS_READ_IN && !AVS_WAITREQUEST_OUT && cfg_hit
      && ((word_idx == `IDX_FRAC_NUM_TOP) || (word_idx == `IDX_FRAC_DEN_TOP))
      |-> AVS_READDATA_OUT[31:7] == 25'h0000000)
    else $error("reserved bits of fraction top register read nonzero");

  chk_status_reserved:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      AVS_READ_IN && !AVS_WAITREQUEST_OUT && status_hit
      |-> AVS_READDATA_OUT[31:2] == 30'h00000000)
    else $error("reserved bits of status register read nonzero");

  chk_unmapped_zero:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      AVS_READ_IN && !AVS_WAITREQUEST_OUT && !cfg_hit && !status_hit
      |-> AVS_READDATA_OUT == 32'h00000000)
    else $error("unmapped address read nonzero");

  chk_bw_flag:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      ##1 BW_HIGH_OUT == ($past(LOOP_BW_SCALE_OUT) > `BW_HIGH_MARGIN_MIN))
    else $error("bandwidth flag does not follow the factor");

  chk_frac_flag:
    assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      ##1 FRACTION_BAD_OUT == (($past(FRACTION_DENOMINATOR_OUT) == 23'h000000)
      || ($past(FRACTION_NUMERATOR_OUT) >= $past(FRACTION_DENOMINATOR_OUT))))
    else $error("fraction flag does not follow numerator and denominator");
endmodule // dpll_reference_profile_regs

//--- dpll_reference_profile_regs_tb.sv
// Purpose: self-checking bench for the reference-four profile register bank
// Assumes: byte address is four times the register index
// Notes: waitrequest and read data are taken at the rising edge, before that edge's updates land
`timescale 1ns/1ps
`include "dpll_ref_params.svh"
module dpll_reference_profile_regs_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [13:0] address = '0;
  logic        rd_req = 1'b0;
  logic        wr_req = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdata;
  logic        waitreq;
  logic        ref_en;
  logic [1:0]  prio;
  logic [15:0] bw;
  logic        high_margin;
  logic [16:0] int_count;
  logic [22:0] num;
  logic [22:0] den;
  logic [17:0] ratio;
  logic        bw_high;
  logic        frac_bad;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [31:0] got;
  // rows: written byte, expected readback, value after reset
  logic [7:0]  wr_tab [13] = '{8'hff, 8'h34, 8'h12, 8'hff, 8'h56, 8'h9a, 8'hff,
                               8'h11, 8'h22, 8'hff, 8'h33, 8'h44, 8'hff};
  logic [7:0]  rd_tab [13] = '{8'h07, 8'h34, 8'h12, 8'h02, 8'h56, 8'h9a, 8'h01,
                               8'h11, 8'h22, 8'h7f, 8'h33, 8'h44, 8'h7f};
  logic [7:0]  rst_tab [13] = '{8'h00, 8'hf4, 8'h01, 8'h00, 8'hcb, 8'h07, 8'h00,
                                8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};

  dpll_reference_profile_regs dpll_reference_profile_regs_inst (
    .CLK_SYS_IN                 (clk),
    .RSTN_IN                    (rstn),
    .AVS_ADDRESS_IN             (address),
    .AVS_READ_IN                (rd_req),
    .AVS_WRITE_IN               (wr_req),
    .AVS_WRITEDATA_IN           (wdata),
    .AVS_BYTEENABLE_IN          (be),
    .AVS_READDATA_OUT           (rdata),
    .AVS_WAITREQUEST_OUT        (waitreq),
    .REF_FOUR_ENABLE_OUT        (ref_en),
    .REF_FOUR_PRIORITY_OUT      (prio),
    .LOOP_BW_SCALE_OUT          (bw),
    .HIGH_MARGIN_FILTER_OUT     (high_margin),
    .INTEGER_FEEDBACK_COUNT_OUT (int_count),
    .FRACTION_NUMERATOR_OUT     (num),
    .FRACTION_DENOMINATOR_OUT   (den),
    .INTEGER_RATIO_OUT          (ratio),
    .BW_HIGH_OUT                (bw_high),
    .FRACTION_BAD_OUT           (frac_bad)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check_rd(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch read at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic check_out(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch port at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one access; held until waitrequest is sampled low at a rising edge, watchdog ends a hang
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d,
                     input logic [3:0] b, output logic [31:0] r);
    @(posedge clk);
    address <= {idx, 2'b00};
    wr_req  <= w;
    rd_req  <= !w;
    wdata   <= {24'h0, d};
    be      <= b;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    r = rdata;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      bus(1'b1, `IDX_PRIORITY_ENABLE + 12'(i), wr_tab[i], 4'hf, got);
      bus(1'b0, `IDX_PRIORITY_ENABLE + 12'(i), 8'h00, 4'hf, got);
      check_rd(got, {24'h0, rd_tab[i]});
    end
    @(negedge clk);
    check_out({30'h0, prio}, 32'h3);
    check_out({31'h0, ref_en}, 32'h1);
    check_out({16'h0, bw}, 32'h1234);
    check_out({31'h0, high_margin}, 32'h1);
    check_out({15'h0, int_count}, 32'h19a56);
    check_out({9'h0, num}, 32'h7f2211);
    check_out({9'h0, den}, 32'h7f4433);
    check_out({14'h0, ratio}, 32'h19a57);
    // unmapped place, lane-0 disabled write, read-only status
    bus(1'b1, `IDX_PROFILE_STATUS + 12'h1, 8'hff, 4'hf, got);
    bus(1'b0, `IDX_PROFILE_STATUS + 12'h1, 8'h00, 4'hf, got);
    check_rd(got, 32'h0);
    bus(1'b1, `IDX_BW_SCALE_LOW, 8'h00, 4'he, got);
    bus(1'b0, `IDX_BW_SCALE_LOW, 8'h00, 4'hf, got);
    check_rd(got, 32'h34);
    bus(1'b1, `IDX_PROFILE_STATUS, 8'hff, 4'hf, got);
    bus(1'b0, `IDX_PROFILE_STATUS, 8'h00, 4'hf, got);
    check_rd(got, 32'h0);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `IDX_PRIORITY_ENABLE, 8'({c[1:0], c[0]}), 4'hf, got);
      @(negedge clk);
      check_out({30'h0, prio}, 32'(c));
      check_out({31'h0, ref_en}, {31'h0, c[0]});
    end
    // 20000 steps of 0.1 Hz is the edge of the high-bandwidth flag
    bus(1'b1, `IDX_BW_SCALE_HIGH, 8'h4e, 4'hf, got);
    bus(1'b1, `IDX_BW_SCALE_LOW, 8'h20, 4'hf, got);
    repeat (2) @(negedge clk);
    check_out({31'h0, bw_high}, 32'h0);
    bus(1'b1, `IDX_BW_SCALE_LOW, 8'h21, 4'hf, got);
    repeat (2) @(negedge clk);
    check_out({31'h0, bw_high}, 32'h1);
    for (int i = 0; i < 3; i++) bus(1'b1, `IDX_FRAC_DEN_LOW + 12'(i), 8'h00, 4'hf, got);
    repeat (2) @(negedge clk);
    check_out({31'h0, frac_bad}, 32'h1);
    bus(1'b0, `IDX_PROFILE_STATUS, 8'h00, 4'hf, got);
    check_rd(got, 32'h3);
    // reset in mid-run must restore every field
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check_out({30'h0, prio}, 32'h0);
    check_out({31'h0, ref_en}, 32'h0);
    check_out({16'h0, bw}, 32'h01f4);
    check_out({31'h0, high_margin}, 32'h0);
    check_out({15'h0, int_count}, 32'h007cb);
    check_out({9'h0, num}, 32'h4);
    check_out({9'h0, den}, 32'h5);
    check_out({14'h0, ratio}, 32'h007cc);
    check_out({31'h0, bw_high}, 32'h0);
    check_out({31'h0, frac_bad}, 32'h0);
    for (int i = 0; i < 13; i++) begin
      bus(1'b0, `IDX_PRIORITY_ENABLE + 12'(i), 8'h00, 4'hf, got);
      check_rd(got, {24'h0, rst_tab[i]});
    end
    // numerator equal to the reset denominator marks the fraction as unusable
    bus(1'b1, `IDX_FRAC_NUM_LOW, 8'h05, 4'hf, got);
    repeat (2) @(negedge clk);
    check_out({31'h0, frac_bad}, 32'h1);
    tally_and_finish();
  end
endmodule // dpll_reference_profile_regs_tb
